/* File: design/omds_map.svh */
// Purpose: Named constants for the operating-mode supervisor and its strap sampling
// Assumes: Included by its bare name from every file that needs a constant
// Notes:   Times are in ns as given; cycle counts are derived inside the modules
`ifndef OMDS_MAP_SVH
`define OMDS_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------------
`define OMDS_CLK_PERIOD_NS   25
`define OMDS_RESET_DELAY_NS  10000000
`define OMDS_DEV_FILT_NS     50000
`define OMDS_CFG_FILT_NS     50000
`define OMDS_INT_PULSE_NS    100000

// ----------------------------------------------------------------------------
// SPI frame width and fixed checksum recovery frames
// ----------------------------------------------------------------------------
`define OMDS_SPI_W           32
`define OMDS_CRC_ON_FRAME    32'h67aaaa0e
`define OMDS_CRC_OFF_FRAME   32'he7aaaac3

// ----------------------------------------------------------------------------
// Reset values, pin levels and strap pin bit positions
// ----------------------------------------------------------------------------
`define OMDS_PIN_IDLE        2'h3
`define OMDS_FILT_RST        1'h1
`define OMDS_CRC_RST         1'h0
`define OMDS_INTN_ACTIVE     1'h0
`define OMDS_PIN_DEV         0
`define OMDS_PIN_CRC         1

`endif

/* File: design/omds_pkg.sv */
// Purpose: Types shared by the operating-mode supervisor files
// Assumes: Nothing beyond the map header
// Notes:   Mode codes are left to the tools
package omds_pkg;

	// ------------------------------------------------------------------------
	// Operating modes
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		OMDS_INIT,
		OMDS_NORMAL,
		OMDS_STOP,
		OMDS_SLEEP,
		OMDS_RESTART,
		OMDS_FAIL_SAFE
	} omds_mode_t;

endpackage

/* File: design/omds_filt_if.sv */
// Purpose: Carrier between the supervisor and one strap filter
// Assumes: raw is already synchronised to the filter clock
// Notes:   preset forces the filtered level to one
`timescale 1ns/1ps
`default_nettype none
interface omds_filt_if;
	logic raw;
	logic preset;
	logic filt;

	modport src (output raw, output preset, input filt);
	modport flt (input raw, input preset, output filt);
endinterface
`default_nettype wire

/* File: design/omds_filter.sv */
// Purpose: Continuous glitch filter for one strap pin
// Assumes: Input already passed a two-flop synchroniser
// Notes:   Output follows the input only after it differs for CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
`include "omds_map.svh"
module omds_filter
	import omds_pkg::*;
#(
	parameter int unsigned CYCLES = 2000
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	omds_filt_if.flt  f
);
	localparam int CNT_W = $clog2(CYCLES + 1);

	logic [CNT_W-1:0] cnt;
	logic             filt;

	// ------------------------------------------------------------------------
	// Filter counter
	// ------------------------------------------------------------------------
	// Counter restarts on any bounce, so a noisy strap never flips the level
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			filt <= `OMDS_FILT_RST;
			cnt  <= '0;
		end else if (f.preset) begin
			filt <= `OMDS_FILT_RST;
			cnt  <= '0;
		end else if (f.raw == filt) begin
			cnt  <= '0;
		end else if (cnt == CNT_W'(CYCLES - 1)) begin
			filt <= f.raw;
			cnt  <= '0;
		end else begin
			cnt  <= cnt + 1'b1;
		end
	end

	assign f.filt = filt;
endmodule
`default_nettype wire

/* File: design/omds_mode_sup.sv */
// Purpose: Operating-mode supervisor with development-mode and checksum straps
// Assumes: Mode requests, faults and SPI frames come decoded on clk_i
// Notes:   Only the two strap pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "omds_map.svh"
module omds_mode_sup
	import omds_pkg::*;
#(
	parameter int unsigned RD_CYCLES       = (`OMDS_RESET_DELAY_NS + `OMDS_CLK_PERIOD_NS - 1) / `OMDS_CLK_PERIOD_NS,
	parameter int unsigned DEV_FILT_CYCLES = (`OMDS_DEV_FILT_NS + `OMDS_CLK_PERIOD_NS - 1) / `OMDS_CLK_PERIOD_NS,
	parameter int unsigned CFG_FILT_CYCLES = (`OMDS_CFG_FILT_NS + `OMDS_CLK_PERIOD_NS - 1) / `OMDS_CLK_PERIOD_NS,
	parameter int unsigned INT_CYCLES      = (`OMDS_INT_PULSE_NS + `OMDS_CLK_PERIOD_NS - 1) / `OMDS_CLK_PERIOD_NS
) (
	input  wire logic                   clk_i,
	input  wire logic                   nrst_i,
	input  wire logic                   main_regulator_output_ok_i,
	input  wire logic                   por_flag_i,
	input  wire logic                   soft_reset_i,
	input  wire logic                   req_normal_i,
	input  wire logic                   req_stop_i,
	input  wire logic                   req_sleep_i,
	input  wire logic                   wake_i,
	input  wire logic                   wd_fail_i,
	input  wire logic                   uv_reset_i,
	input  wire logic                   thermal_shutdown_i,
	input  wire logic                   wd_reset_reenable_i,
	input  wire logic                   spi_frame_valid_i,
	input  wire logic [`OMDS_SPI_W-1:0] spi_frame_i,
	input  wire logic                   intn_test_i,
	input  wire logic                   modulation_checksum_strap_pin_i,
	output var  omds_mode_t             mode_o,
	output var  logic                   main_reg_en_o,
	output var  logic                   host_reset_output_low_o,
	output var  logic                   intn_test_o,
	output var  logic                   intn_test_oe_o,
	output var  logic                   intn_pullup_en_o,
	output var  logic                   dev_mode_o,
	output var  logic                   crc_en_o,
	output var  logic                   wd_long_start_o
);
	localparam int RD_W  = $clog2(RD_CYCLES + 1);
	localparam int INT_W = $clog2(INT_CYCLES + 1);

	omds_mode_t       mode;
	omds_mode_t       next_mode;
	logic             main_reg_en;
	logic             host_reset_output_low;
	logic             pullup_en;
	logic [RD_W-1:0]  rd_cnt;
	logic             from_por;
	logic             dev_mode;
	logic             crc_en;
	logic             wd_long;
	logic [INT_W-1:0] int_cnt;
	logic             intn_oe;
	logic             intn_drv;
	logic [1:0]       pin_s1;
	logic [1:0]       pin_s2;
	logic             entering;
	logic             release_now;
	logic             monitoring;
	logic             crc_window;
	logic             wd_to_reset;
	logic             wd_to_intn;

	omds_filt_if dev_fi ();
	omds_filt_if crc_fi ();

	// ------------------------------------------------------------------------
	// Strap pin synchronisers and filters
	// ------------------------------------------------------------------------
	// Idle level is high: the checksum pin reads high when unloaded, the development pin once its weak pull-up is on
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_s1 <= `OMDS_PIN_IDLE;
			pin_s2 <= `OMDS_PIN_IDLE;
		end else begin
			pin_s1 <= {modulation_checksum_strap_pin_i, intn_test_i};
			pin_s2 <= pin_s1;
		end
	end

	// The development filtered copy restarts at one on the reset release edge; the checksum copy is never preset
	assign dev_fi.raw    = pin_s2[`OMDS_PIN_DEV];
	assign dev_fi.preset = release_now;
	assign crc_fi.raw    = pin_s2[`OMDS_PIN_CRC];
	assign crc_fi.preset = `OMDS_FILT_RST ^ `OMDS_FILT_RST;

	omds_filter #(
		.CYCLES (DEV_FILT_CYCLES)
	) u_dev_filt (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.f      (dev_fi)
	);

	omds_filter #(
		.CYCLES (CFG_FILT_CYCLES)
	) u_crc_filt (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.f      (crc_fi)
	);

	// ------------------------------------------------------------------------
	// Decoded conditions
	// ------------------------------------------------------------------------
	// Watchdog is only live once the host is out of reset
	assign wd_to_reset = wd_fail_i && host_reset_output_low && (!dev_mode || wd_reset_reenable_i);
	assign wd_to_intn  = wd_fail_i && host_reset_output_low && dev_mode && !wd_reset_reenable_i;
	assign entering    = (next_mode != mode);
	assign release_now = ((mode == OMDS_INIT) || (mode == OMDS_RESTART)) && !host_reset_output_low
	                     && main_regulator_output_ok_i && (rd_cnt == RD_W'(RD_CYCLES - 1));
	// Development strap window: power-up init, supply and flag good, reset high
	assign monitoring  = (mode == OMDS_INIT) && from_por && main_regulator_output_ok_i
	                     && por_flag_i && host_reset_output_low;
	// Checksum strap window: reset delay of power-up init or of restart
	assign crc_window  = (((mode == OMDS_INIT) && from_por) || (mode == OMDS_RESTART))
	                     && main_regulator_output_ok_i && por_flag_i && !host_reset_output_low;

	// ------------------------------------------------------------------------
	// Mode transitions
	// ------------------------------------------------------------------------
	// Thermal shutdown beats everything; faults beat host requests, except soft reset, which beats faults
	always_comb begin
		next_mode = mode;
		if (thermal_shutdown_i) begin
			next_mode = OMDS_FAIL_SAFE;
		end else begin
			unique case (mode)
				OMDS_INIT: begin
					if (uv_reset_i || wd_to_reset) begin
						next_mode = OMDS_RESTART;
					end else if (host_reset_output_low && spi_frame_valid_i) begin
						next_mode = OMDS_NORMAL;
					end
				end
				OMDS_NORMAL: begin
					if (soft_reset_i) begin
						next_mode = OMDS_INIT;
					end else if (uv_reset_i || wd_to_reset) begin
						next_mode = OMDS_RESTART;
					end else if (req_stop_i) begin
						next_mode = OMDS_STOP;
					end else if (req_sleep_i) begin
						next_mode = OMDS_SLEEP;
					end
				end
				OMDS_STOP: begin
					if (soft_reset_i) begin
						next_mode = OMDS_INIT;
					end else if (uv_reset_i || wd_to_reset) begin
						next_mode = OMDS_RESTART;
					end else if (req_normal_i) begin
						next_mode = OMDS_NORMAL;
					end
				end
				OMDS_SLEEP: begin
					if (wake_i) begin
						next_mode = OMDS_RESTART;
					end
				end
				OMDS_RESTART: begin
					if (release_now) begin
						next_mode = OMDS_NORMAL;
					end
				end
				OMDS_FAIL_SAFE: begin
					if (wake_i) begin
						next_mode = OMDS_RESTART;
					end
				end
			endcase
		end
	end

	// Mode register and main regulator enable, both follow the next mode
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode        <= OMDS_INIT;
			main_reg_en <= 1'b1;
		end else begin
			mode        <= next_mode;
			main_reg_en <= !((next_mode == OMDS_SLEEP) || (next_mode == OMDS_FAIL_SAFE));
		end
	end

	// Remembers whether the current init came from power-up
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			from_por <= 1'b1;
		end else if (entering && (mode == OMDS_INIT)) begin
			from_por <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Host reset output, reset delay and weak pull-up
	// ------------------------------------------------------------------------
	// Release waits for a good main supply, so a sagging rail stretches reset
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			host_reset_output_low <= 1'b0;
			pullup_en             <= 1'b0;
			rd_cnt                <= '0;
		end else if (entering && (next_mode != OMDS_NORMAL) && (next_mode != OMDS_STOP)) begin
			host_reset_output_low <= 1'b0;
			pullup_en             <= 1'b0;
			rd_cnt                <= '0;
		end else if (release_now) begin
			host_reset_output_low <= 1'b1;
			pullup_en             <= 1'b1;
			rd_cnt                <= '0;
		end else if (((mode == OMDS_INIT) || (mode == OMDS_RESTART)) && !host_reset_output_low
		             && main_regulator_output_ok_i) begin
			rd_cnt                <= rd_cnt + 1'b1;
		end
	end

	// Long open window start at release in init, and at every release in development mode
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_long <= 1'b0;
		end else begin
			wd_long <= release_now && ((mode == OMDS_INIT) || dev_mode);
		end
	end

	// ------------------------------------------------------------------------
	// Development mode latch
	// ------------------------------------------------------------------------
	// Cleared only by power-on reset; later modes never look at the pin again
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dev_mode <= 1'b0;
		end else if (monitoring && spi_frame_valid_i && !dev_fi.filt) begin
			dev_mode <= 1'b1;
		end else if (monitoring && entering && !spi_frame_valid_i) begin
			dev_mode <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Checksum enable
	// ------------------------------------------------------------------------
	// Strap low means enabled; recovery frames work in normal mode only
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			crc_en <= `OMDS_CRC_RST;
		end else if (release_now && crc_window) begin
			crc_en <= !crc_fi.filt;
		end else if ((mode == OMDS_NORMAL) && spi_frame_valid_i) begin
			if (spi_frame_i == `OMDS_CRC_ON_FRAME) begin
				crc_en <= 1'b1;
			end else if (spi_frame_i == `OMDS_CRC_OFF_FRAME) begin
				crc_en <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt pulse on the interrupt/test pin
	// ------------------------------------------------------------------------
	// A new failure during a pulse restarts it rather than queueing a second
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			intn_oe  <= 1'b0;
			int_cnt  <= '0;
			intn_drv <= `OMDS_INTN_ACTIVE;
		end else begin
			intn_drv <= `OMDS_INTN_ACTIVE;
			if (wd_to_intn) begin
				intn_oe <= 1'b1;
				int_cnt <= '0;
			end else if (intn_oe && (int_cnt == INT_W'(INT_CYCLES - 1))) begin
				intn_oe <= 1'b0;
			end else if (intn_oe) begin
				int_cnt <= int_cnt + 1'b1;
			end
		end
	end

	// Outputs straight from their flip-flops
	assign mode_o                  = mode;
	assign main_reg_en_o           = main_reg_en;
	assign host_reset_output_low_o = host_reset_output_low;
	assign intn_test_o             = intn_drv;
	assign intn_test_oe_o          = intn_oe;
	assign intn_pullup_en_o        = pullup_en;
	assign dev_mode_o              = dev_mode;
	assign crc_en_o                = crc_en;
	assign wd_long_start_o         = wd_long;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_strap_cmd;
		monitoring && spi_frame_valid_i && !dev_fi.filt;
	endsequence

	sequence s_dev_wd_fail;
		(mode == OMDS_NORMAL) && dev_mode_o && wd_fail_i && !wd_reset_reenable_i
		&& !thermal_shutdown_i && !soft_reset_i && !uv_reset_i;
	endsequence

	chk_stop_reg_on: assert property (mode_o == OMDS_STOP |-> main_reg_en_o)
		else $error("Main regulator off in stop mode");
	chk_sleep_reg_off: assert property (mode_o == OMDS_SLEEP |-> !main_reg_en_o)
		else $error("Main regulator on in sleep mode");
	chk_sleep_wake: assert property ((mode == OMDS_SLEEP) && wake_i && !thermal_shutdown_i
		|=> (mode == OMDS_RESTART) && !host_reset_output_low_o)
		else $error("Wake in sleep did not enter restart with host reset");
	chk_thermal_fs: assert property (thermal_shutdown_i |=> mode == OMDS_FAIL_SAFE ##1 !main_reg_en_o || thermal_shutdown_i)
		else $error("Thermal shutdown did not enter fail-safe");
	chk_soft_reset: assert property ((mode == OMDS_NORMAL) && soft_reset_i && !thermal_shutdown_i
		|=> (mode == OMDS_INIT) && !host_reset_output_low_o)
		else $error("Soft reset did not re-enter init");
	chk_dev_wd_intn: assert property (s_dev_wd_fail and (!req_stop_i && !req_sleep_i)
		|=> (mode == OMDS_NORMAL) && intn_test_oe_o && host_reset_output_low_o)
		else $error("Development watchdog failure reset the host");
	chk_wd_reenable: assert property ((mode == OMDS_NORMAL) && dev_mode_o && wd_fail_i && wd_reset_reenable_i
		&& !thermal_shutdown_i && !soft_reset_i |=> mode == OMDS_RESTART)
		else $error("Re-enabled watchdog reset not applied");
	chk_init_long_win: assert property ($rose(host_reset_output_low_o) && ($past(mode) == OMDS_INIT)
		|-> wd_long_start_o ##1 !wd_long_start_o)
		else $error("No long open window at init release");
	chk_dev_long_win: assert property ($rose(host_reset_output_low_o) && $past(dev_mode) |-> wd_long_start_o)
		else $error("No long open window in development mode");
	chk_dev_latch: assert property (s_strap_cmd |=> dev_mode_o ##1 dev_mode_o)
		else $error("Development mode not latched");
	chk_dev_pulled_up: assert property (monitoring && spi_frame_valid_i && dev_fi.filt && !dev_mode_o
		|=> !dev_mode_o)
		else $error("Development mode entered with pin high");
	chk_dev_window: assert property (!dev_mode_o && !monitoring |=> !dev_mode_o)
		else $error("Development mode latched outside its window");
	chk_dev_hold: assert property (dev_mode_o |=> dev_mode_o)
		else $error("Development mode dropped before power-on reset");
	chk_filt_start: assert property ($rose(host_reset_output_low_o) |-> dev_fi.filt)
		else $error("Filtered pin not one at reset release");
	chk_pullup_rel: assert property (host_reset_output_low_o |-> intn_pullup_en_o)
		else $error("Weak pull-up missing after release");
	chk_crc_strap: assert property (release_now && crc_window |=> crc_en_o == !$past(crc_fi.filt))
		else $error("Checksum strap not latched at release");
	chk_crc_frame: assert property ((mode == OMDS_NORMAL) && spi_frame_valid_i
		&& (spi_frame_i == `OMDS_CRC_ON_FRAME) |=> crc_en_o)
		else $error("Checksum enable frame ignored");
endmodule
`default_nettype wire

/* File: verification/omds_host_model.sv */
// Purpose: Host-side pin model: external straps and the interrupt/test wire
// Assumes: The device only ever pulls the pin low, and only while its enable is high
// Notes:   An unloaded checksum pin is taken to read high, through an internal pull
`timescale 1ns/1ps
`default_nettype none
module omds_host_model (
	input  wire logic clk_i,
	input  wire logic dev_pd_i,
	input  wire logic crc_pd_i,
	input  wire logic pin_drv_i,
	input  wire logic pin_oe_i,
	input  wire logic pin_pu_i,
	output var  logic intn_pin_o,
	output var  logic crc_pin_o
);
	logic flt_q = 1'b0;

	// A floating pin wanders every cycle, so no level is trusted by luck
	always @(posedge clk_i) begin
		flt_q <= ~flt_q;
	end

	// Device drive wins, then the fitted pull-down, then the weak pull-up
	always_comb begin
		if (pin_oe_i) intn_pin_o = pin_drv_i;
		else if (dev_pd_i) intn_pin_o = 1'b0;
		else if (pin_pu_i) intn_pin_o = 1'b1;
		else intn_pin_o = flt_q;
	end

	// A fitted pull-down asks for the checksum
	assign crc_pin_o = crc_pd_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verification/test_omds_mode_sup.sv */
// Purpose: Self-checking bench for the operating-mode supervisor
// Assumes: Short counts: reset delay 20, filters 4, interrupt pulse 5 cycles
// Notes:   Inputs change on the falling edge and outputs are read there too
`timescale 1ns/1ps
`default_nettype none
`include "omds_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_omds_mode_sup
	import omds_pkg::*;
;
	logic clk_i = 1'b0, nrst_i = 1'b0, ok_i = 1'b1, por_i = 1'b1, soft_i = 1'b0;
	logic rn_i = 1'b0, rs_i = 1'b0, rsl_i = 1'b0, wake_i = 1'b0, wdf_i = 1'b0;
	logic uv_i = 1'b0, th_i = 1'b0, reen_i = 1'b0, fv_i = 1'b0, dpd = 1'b0, cpd = 1'b0;
	logic [31:0] fr_i = 32'h0;
	logic intn_pin, crc_pin, mreg, hrst, p_drv, p_oe, p_pu, dev, crc, wdl;
	omds_mode_t mode;
	int n_mismatch = 0;
	int compares = 0;

	always #12.5 clk_i = ~clk_i;

	// ------------------------------------------------------------------------
	// Device and host pins
	// ------------------------------------------------------------------------
	omds_mode_sup #(.RD_CYCLES(20), .DEV_FILT_CYCLES(4), .CFG_FILT_CYCLES(4), .INT_CYCLES(5)) dut_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .main_regulator_output_ok_i(ok_i), .por_flag_i(por_i),
		.soft_reset_i(soft_i), .req_normal_i(rn_i), .req_stop_i(rs_i), .req_sleep_i(rsl_i),
		.wake_i(wake_i), .wd_fail_i(wdf_i), .uv_reset_i(uv_i), .thermal_shutdown_i(th_i),
		.wd_reset_reenable_i(reen_i), .spi_frame_valid_i(fv_i), .spi_frame_i(fr_i),
		.intn_test_i(intn_pin), .modulation_checksum_strap_pin_i(crc_pin), .mode_o(mode),
		.main_reg_en_o(mreg), .host_reset_output_low_o(hrst), .intn_test_o(p_drv),
		.intn_test_oe_o(p_oe), .intn_pullup_en_o(p_pu), .dev_mode_o(dev), .crc_en_o(crc),
		.wd_long_start_o(wdl));
	omds_host_model host_u (.clk_i(clk_i), .dev_pd_i(dpd), .crc_pd_i(cpd), .pin_drv_i(p_drv),
		.pin_oe_i(p_oe), .pin_pu_i(p_pu), .intn_pin_o(intn_pin), .crc_pin_o(crc_pin));

	task automatic end_sim();
		$display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask

	task automatic frame(input logic [31:0] f);
		fr_i = f;
		fv_i = 1'b1;
		tick(1);
		fv_i = 1'b0;
		tick(1);
	endtask

	// Bounded wait for the host reset to release; reports the long-window pulse
	task automatic wait_rel(output logic seen, output int n);
		seen = 1'b0;
		for (n = 0; n < 60 && hrst !== 1'b1; n++) begin
			tick(1);
			if (wdl === 1'b1) seen = 1'b1;
		end
		if (hrst !== 1'b1) begin
			n_mismatch++;
			end_sim();
		end
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic power_up(input logic d, input logic c, input logic p);
		logic seen;
		int n;
		nrst_i = 1'b0;
		dpd = d;
		cpd = c;
		por_i = p;
		tick(16);
		nrst_i = 1'b1;
		tick(1);
		`CHK("reset held", 1'b0, hrst)
		wait_rel(seen, n);
		`CHK("delay", 1'b1, n >= 17 && n <= 22)
		`CHK("long window", 1'b1, seen)
		`CHK("pull-up", 1'b1, p_pu)
		`CHK("crc strap", c & p, crc)
		`CHK("init", OMDS_INIT, mode)
		tick(8);
		frame(32'h0);
		`CHK("normal", OMDS_NORMAL, mode)
		`CHK("dev mode", d & p, dev)
	endtask

	task automatic sc_modes();
		int n;
		logic seen;
		power_up(1'b0, 1'b0, 1'b1);
		frame(`OMDS_CRC_ON_FRAME);
		`CHK("crc on", 1'b1, crc)
		frame(`OMDS_CRC_OFF_FRAME);
		`CHK("crc off", 1'b0, crc)
		pulse(rs_i);
		`CHK("stop", OMDS_STOP, mode)
		`CHK("stop reg", 1'b1, mreg)
		frame(`OMDS_CRC_ON_FRAME);
		pulse(wake_i);
		`CHK("crc frame in stop", 1'b0, crc)
		`CHK("wake in stop", OMDS_STOP, mode)
		pulse(rn_i);
		pulse(rsl_i);
		`CHK("sleep", OMDS_SLEEP, mode)
		`CHK("sleep reg", 1'b0, mreg)
		pulse(wake_i);
		`CHK("wake restart", OMDS_RESTART, mode)
		wait_rel(seen, n);
		tick(1);
		`CHK("restart to normal", OMDS_NORMAL, mode)
		pulse(wdf_i);
		`CHK("wd restart", OMDS_RESTART, mode)
		`CHK("wd host reset", 1'b0, hrst)
		wait_rel(seen, n);
		tick(1);
		pulse(uv_i);
		`CHK("uv restart", OMDS_RESTART, mode)
		wait_rel(seen, n);
		tick(1);
		pulse(th_i);
		`CHK("fail-safe", OMDS_FAIL_SAFE, mode)
		pulse(wake_i);
		wait_rel(seen, n);
		tick(1);
		pulse(soft_i);
		`CHK("soft reset", OMDS_INIT, mode)
	endtask

	task automatic sc_dev();
		int c;
		int n;
		logic seen;
		power_up(1'b1, 1'b0, 1'b0);
		power_up(1'b1, 1'b1, 1'b1);
		wdf_i = 1'b1;
		tick(1);
		wdf_i = 1'b0;
		c = 0;
		for (int i = 0; i < 10; i++) begin
			if (p_oe === 1'b1) c++;
			tick(1);
		end
		`CHK("int pulse", 5, c)
		`CHK("int drive level", 1'b0, p_drv)
		`CHK("no restart", OMDS_NORMAL, mode)
		`CHK("host kept", 1'b1, hrst)
		reen_i = 1'b1;
		pulse(wdf_i);
		`CHK("reenabled", OMDS_RESTART, mode)
		wait_rel(seen, n);
		`CHK("dev long window", 1'b1, seen)
		`CHK("dev held", 1'b1, dev)
	endtask

	// Pull-down fitted, but init is left by a fault before any frame
	task automatic sc_no_cmd();
		logic seen;
		int n;
		nrst_i = 1'b0;
		dpd = 1'b1;
		cpd = 1'b0;
		por_i = 1'b1;
		tick(16);
		nrst_i = 1'b1;
		wait_rel(seen, n);
		pulse(uv_i);
		`CHK("uv in init", OMDS_RESTART, mode)
		wait_rel(seen, n);
		tick(1);
		frame(32'h0);
		`CHK("normal after uv", OMDS_NORMAL, mode)
		`CHK("no dev after uv", 1'b0, dev)
	endtask

	initial begin
		sc_modes();
		sc_no_cmd();
		sc_dev();
		end_sim();
	end
endmodule
`default_nettype wire
